// ===== src/ugc_general_cmd.sv
// Purpose: General command interpreter of a full-speed USB peripheral controller.
// Assumes: Strobes, phase and data come from a processor on another clock.
//          Data lines are held stable for several cycles around a write strobe.
// Notes:   Each access is a command code write followed by a data phase.
//          Power-on leaves it unlocked; a suspend from the engine locks it.
// Operation
// - A0..AF read one endpoint's result byte
// - New transaction replaces stored result byte
// - Bit 7 flags event before previous read
// - Bit 6 holds toggle of last good packet
// - Bit 0 marks success; bit 5 reserved
// - Error field bits 4..1, codes 0..7
// - Error field codes 8..15
// - Suspend blocks all register writes but the B0 key
// - Reads return zero while locked
// - B0 plus key AA37h unlocks, low first
// - B2/B3 access 13-bit spare word, reset zero
// - B4 returns frame of last good SOF
// - Frame undefined after bus reset until SOF
// - B5 returns part code and BCD revision
`timescale 1ns/10ps
module ugc_general_cmd #(
    parameter bit         BYTE_BUS    = 1'b0,
    parameter logic [7:0] PART_CODE   = 8'h5a,   // Arbitrary value.
    parameter logic [7:0] SILICON_REV = 8'h10    // Arbitrary value.
) (
    // Clock and reset.
    input  wire logic                 mclk,
    input  wire logic                 rst,
    // Processor pins.
    input  wire logic                 cpu_cs_n,
    input  wire logic                 cpu_rd_n,
    input  wire logic                 cpu_wr_n,
    input  wire logic                 phase_select_line,
    input  wire logic [15:0]          cpu_din,
    output logic      [15:0]          cpu_dout,
    output logic                      cpu_doe,
    // Protocol engine events.
    input  wire ugc_pkg::ugc_txn_t    txn,
    input  wire ugc_pkg::ugc_sof_t    sof,
    input  wire logic                 usb_suspend,
    // Protection state for buffer memory.
    output logic                      write_protect
);
    import ugc_pkg::*;

    ugc_state_t q;
    ugc_state_t d;

    // Only the second synchroniser stage is read, so a metastable first stage
    // never reaches the decoders.
    // Strobe edges seen after the synchronisers.
    logic        rd_act;
    logic        wr_act;
    logic        rd_beg;
    logic        rd_end;
    logic        wr_end;
    logic        cmd_ph;
    logic        word_done;
    logic [15:0] word_in;
    logic [7:0]  cur_res;
    logic        clr_hit;

    assign rd_act    = !q.pin_s2[UGC_PIN_CS] && !q.pin_s2[UGC_PIN_RD];
    assign wr_act    = !q.pin_s2[UGC_PIN_CS] && !q.pin_s2[UGC_PIN_WR];
    assign rd_beg    = rd_act && !q.rd_p;
    assign rd_end    = !rd_act && q.rd_p;
    assign wr_end    = !wr_act && q.wr_p;
    assign cmd_ph    = q.pin_s2[UGC_PIN_PH];
    assign word_done = wr_end && !cmd_ph && (!BYTE_BUS || q.idx);
    // On the byte bus a word acts on its second byte; a new command code drops
    // a lone first byte.
    assign word_in   = BYTE_BUS ? {q.din_s2[7:0], q.lo} : q.din_s2;
    assign cur_res   = q.res[q.code[3:0]];
    // A finished result read of the endpoint that is reporting right now.
    assign clr_hit   = rd_end && !cmd_ph && !q.locked &&
                       q.code[7:4] == UGC_CMD_RESULT_NIB && txn.valid &&
                       txn.ep == q.code[3:0];

    // Word presented for a read; everything reads zero while locked.
    // Pending marks survive a locked read, so firmware must unlock before it
    // polls results. Unknown codes read as zero.
    function automatic logic [15:0] read_word(input ugc_state_t s);
        logic [15:0] w;
        w = 16'h0000;
        if (!s.locked) begin
            if (s.code[7:4] == UGC_CMD_RESULT_NIB) begin
                w[7:0] = s.res[s.code[3:0]];
            end else begin
                unique case (s.code)
                    UGC_CMD_SPARE_RD: w[UGC_SPARE_W-1:0] = s.spare;
                    UGC_CMD_FRAME_RD: w[UGC_FRAME_W-1:0] = s.frame;
                    UGC_CMD_ID_RD:    w = {PART_CODE, SILICON_REV};
                    default:          w = 16'h0000;
                endcase
            end
        end
        return w;
    endfunction

    // Next-state logic for the whole interpreter.
    always_comb begin
        logic [15:0] w;
        logic        ovr;
        w = read_word(q);
        ovr = 1'b0;
        d = q;
        // Data is used only once a strobe end is seen, by which time the writer
        // has held it stable for several cycles, so no word handshake is needed.
        d.pin_s1 = {phase_select_line, cpu_wr_n, cpu_rd_n, cpu_cs_n};
        d.pin_s2 = q.pin_s1;
        d.din_s1 = cpu_din;
        d.din_s2 = q.din_s1;
        d.rd_p = rd_act;
        d.wr_p = wr_act;

        // Command phase takes a new code and restarts byte pairing.
        if (wr_end && cmd_ph) begin
            d.code = q.din_s2[7:0];
            d.idx = 1'b0;
        end else if (wr_end) begin
            d.idx = BYTE_BUS ? !q.idx : 1'b0;
            d.lo = q.din_s2[7:0];
        end

        // Whole data words: unlock key and spare word.
        if (word_done && q.code == UGC_CMD_UNLOCK && word_in == UGC_UNLOCK_KEY) begin
            d.locked = 1'b0;
        end
        if (word_done && q.code == UGC_CMD_SPARE_WR && !q.locked) begin
            d.spare = word_in[UGC_SPARE_W-1:0];
        end

        // Data-phase read strobes drive the bus for as long as they are held.
        if (rd_beg && !cmd_ph) begin
            d.doe = 1'b1;
            d.dout = BYTE_BUS ? {8'h00, (q.idx ? w[15:8] : w[7:0])} : w;
        end
        if (rd_end) begin
            d.doe = 1'b0;
            d.dout = 16'h0000;
            if (!cmd_ph) begin
                d.idx = BYTE_BUS ? !q.idx : 1'b0;
                if (!q.locked && q.code[7:4] == UGC_CMD_RESULT_NIB) begin
                    d.pend[q.code[3:0]] = 1'b0;
                end
            end
        end

        // A new transaction replaces the result; the set beats a read clear.
        if (txn.valid) begin
            ovr = q.pend[txn.ep] && !clr_hit;
            d.pend[txn.ep] = 1'b1;
            d.res[txn.ep][UGC_RES_OVR_BIT] = ovr;
            if (txn.ok) begin
                d.res[txn.ep][UGC_RES_TOG_BIT] = txn.toggle;
            end
            d.res[txn.ep][UGC_RES_TOG_BIT-1] = 1'b0;
            d.res[txn.ep][UGC_RES_ERR_LSB+:4] = txn.err;
            d.res[txn.ep][UGC_RES_OK_BIT] = txn.ok;
        end

        // Frame value is simply held across a bus reset until the next SOF.
        if (sof.valid) begin
            d.frame = sof.frame;
        end

        // Suspend locks and wins over a key arriving in the same cycle.
        if (usb_suspend) begin
            d.locked = 1'b1;
        end
    end

    // State register. The synchronisers reset to the idle strobe level, since
    // an all-zero reset would look like a read and a write the moment it ends.
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            q <= UGC_STATE_RST;
        end else begin
            q <= d;
        end
    end

    // Outputs come straight from the state register.
    assign cpu_dout      = q.dout;
    assign cpu_doe       = q.doe;
    assign write_protect = q.locked;

    // Assertions run on the system clock and sleep while reset is high.
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (rst);

    // Result reads, result bookkeeping, locking, spare word, frame, identity and command code.
    AST_RESULT_READ: assert property (
        rd_beg && !cmd_ph && !q.locked && q.code[7:4] == UGC_CMD_RESULT_NIB && !BYTE_BUS
        |=> cpu_doe && cpu_dout == {8'h00, $past(cur_res)})
        else $error("Result byte not presented on read.");

    AST_RESULT_REPLACE: assert property (
        txn.valid |=> q.res[$past(txn.ep)][4:0] == {$past(txn.err), $past(txn.ok)})
        else $error("Result not replaced by new transaction.");

    AST_OVERRUN: assert property (
        txn.valid && q.pend[txn.ep] && !rd_end |=> q.res[$past(txn.ep)][UGC_RES_OVR_BIT])
        else $error("Overrun flag missing.");

    AST_TOGGLE: assert property (
        txn.valid && txn.ok |=> q.res[$past(txn.ep)][UGC_RES_TOG_BIT] == $past(txn.toggle))
        else $error("Toggle bit wrong.");

    AST_RESERVED: assert property (
        cpu_doe && q.code[7:4] == UGC_CMD_RESULT_NIB |-> cpu_dout[15:8] == 8'h00 && !cpu_dout[5])
        else $error("Reserved bits not zero.");

    AST_NO_WRITE_LOCKED: assert property (
        q.locked && !(word_done && q.code == UGC_CMD_UNLOCK) |=> $stable(q.spare))
        else $error("Spare word changed while locked.");

    AST_READ_LOCKED: assert property (
        rd_beg && q.locked |=> cpu_dout == 16'h0000)
        else $error("Read returned data while locked.");

    AST_UNLOCK: assert property (
        word_done && q.code == UGC_CMD_UNLOCK && word_in == UGC_UNLOCK_KEY && !usb_suspend
        |=> !write_protect)
        else $error("Key did not unlock.");

    AST_SPARE_WR: assert property (
        word_done && q.code == UGC_CMD_SPARE_WR && !q.locked
        |=> q.spare == $past(word_in[UGC_SPARE_W-1:0]) [*2])
        else $error("Spare word not stored.");

    AST_FRAME: assert property (
        sof.valid |=> q.frame == $past(sof.frame))
        else $error("Frame number not captured.");

    AST_ID: assert property (
        rd_beg && !cmd_ph && !q.locked && q.code == UGC_CMD_ID_RD && !BYTE_BUS
        |=> cpu_dout == {PART_CODE, SILICON_REV})
        else $error("Identity word wrong.");

    AST_CODE: assert property (
        wr_end && cmd_ph |=> q.code == $past(q.din_s2[7:0]) && !q.idx)
        else $error("Command code not latched.");

    // Read answers of the other registers, the byte-bus upper lines and the end of every answer.
    AST_SPARE_READ: assert property (
        rd_beg && !cmd_ph && !q.locked && q.code == UGC_CMD_SPARE_RD && !BYTE_BUS
        |=> cpu_dout == {3'h0, $past(q.spare)})
        else $error("Spare word not presented on read.");

    AST_FRAME_READ: assert property (
        rd_beg && !cmd_ph && !q.locked && q.code == UGC_CMD_FRAME_RD && !BYTE_BUS
        |=> cpu_dout == {5'h00, $past(q.frame)})
        else $error("Frame number not presented on read.");

    AST_ANSWER_END: assert property (
        rd_end |=> !cpu_doe && cpu_dout == 16'h0000)
        else $error("Read answer outlived its strobe.");

    AST_BYTE_UPPER: assert property (
        rd_beg && BYTE_BUS |=> cpu_dout[15:8] == 8'h00)
        else $error("Upper byte lines driven on byte bus.");

    // Pending marks, result bytes and protection state.
    AST_PEND_SET: assert property (
        txn.valid |=> q.pend[$past(txn.ep)])
        else $error("Pending mark not set by transaction.");

    AST_OVR_CLEAR: assert property (
        txn.valid && !q.pend[txn.ep] |=> !q.res[$past(txn.ep)][UGC_RES_OVR_BIT])
        else $error("Overrun flag set without an status_overrun_flag result.");

    AST_RESULT_KEEP: assert property (
        !txn.valid |=> $stable(q.res))
        else $error("Result changed without a transaction.");

    AST_LOCKED_NO_CLEAR: assert property (
        rd_end && !cmd_ph && q.locked && !txn.valid |=> $stable(q.pend))
        else $error("Locked read cleared a pending mark.");

    AST_SUSPEND_LOCK: assert property (
        usb_suspend |=> write_protect)
        else $error("Suspend did not lock.");

    AST_WRONG_KEY: assert property (
        word_done && q.code == UGC_CMD_UNLOCK && word_in != UGC_UNLOCK_KEY && q.locked
        |=> write_protect)
        else $error("Wrong key unlocked.");

    // Covers for the main scenarios.
    COV_UNLOCK: cover property (q.locked ##[1:200] !q.locked);
    COV_OVERRUN: cover property (txn.valid && q.pend[txn.ep]);
    COV_SPARE: cover property (word_done && q.code == UGC_CMD_SPARE_WR && !q.locked);
    COV_ID_READ: cover property (rd_beg && q.code == UGC_CMD_ID_RD && !q.locked);
    COV_BYTE_KEY: cover property (BYTE_BUS && word_done && q.code == UGC_CMD_UNLOCK);

endmodule

// ===== src/ugc_pkg.sv
// Purpose: Shared constants and types for the general command interpreter.
// Assumes: One system clock; the protocol engine delivers events on that clock.
// Notes:   Command codes, the unlock key and field positions live here only.
package ugc_pkg;

    // Command codes carried on the low byte lines in the command phase.
    localparam logic [3:0] UGC_CMD_RESULT_NIB = 4'ha;
    localparam logic [7:0] UGC_CMD_UNLOCK     = 8'hb0;
    localparam logic [7:0] UGC_CMD_SPARE_WR   = 8'hb2;
    localparam logic [7:0] UGC_CMD_SPARE_RD   = 8'hb3;
    localparam logic [7:0] UGC_CMD_FRAME_RD   = 8'hb4;
    localparam logic [7:0] UGC_CMD_ID_RD      = 8'hb5;

    // Key that lifts write protection after a resume.
    localparam logic [15:0] UGC_UNLOCK_KEY = 16'haa37;

    // Widths and reset values.
    localparam int         UGC_EP_NUM     = 16;
    localparam int         UGC_SPARE_W    = 13;
    localparam int         UGC_FRAME_W    = 11;
    localparam logic [7:0] UGC_RES_RST    = 8'h00;

    // Result byte layout.
    localparam int UGC_RES_OVR_BIT = 7;
    localparam int UGC_RES_TOG_BIT = 6;
    localparam int UGC_RES_ERR_LSB = 1;
    localparam int UGC_RES_OK_BIT  = 0;

    // Synchronised pin vector layout.
    localparam int UGC_PIN_CS  = 0;
    localparam int UGC_PIN_RD  = 1;
    localparam int UGC_PIN_WR  = 2;
    localparam int UGC_PIN_PH  = 3;

    // Last-transaction error codes reported by the protocol engine.
    typedef enum logic [3:0] {
        UGC_ERR_NONE = 4'h0, UGC_ERR_PID_CHK = 4'h1, UGC_ERR_PID_UNK = 4'h2,
        UGC_ERR_UNEXP = 4'h3, UGC_ERR_TOK_CRC = 4'h4, UGC_ERR_DAT_CRC = 4'h5,
        UGC_ERR_TIMEOUT = 4'h6, UGC_ERR_BABBLE = 4'h7, UGC_ERR_EOP = 4'h8,
        UGC_ERR_NAK = 4'h9, UGC_ERR_STALL = 4'ha, UGC_ERR_OVERFLOW = 4'hb,
        UGC_ERR_ISO_EMPTY = 4'hc, UGC_ERR_STUFF = 4'hd, UGC_ERR_SYNC = 4'he,
        UGC_ERR_TOGGLE = 4'hf
    } ugc_err_t;

    // One transaction report from the protocol engine.
    typedef struct packed {
        logic       valid;
        logic [3:0] ep;
        logic       ok;
        logic       toggle;
        ugc_err_t   err;
    } ugc_txn_t;

    // One good start-of-frame report.
    typedef struct packed {
        logic                   valid;
        logic [UGC_FRAME_W-1:0] frame;
    } ugc_sof_t;

    // Whole state of the interpreter.
    typedef struct packed {
        logic [3:0]                   pin_s1;
        logic [3:0]                   pin_s2;
        logic [15:0]                  din_s1;
        logic [15:0]                  din_s2;
        logic                         rd_p;
        logic                         wr_p;
        logic [7:0]                   code;
        logic                         idx;
        logic [7:0]                   lo;
        logic                         locked;
        logic [UGC_SPARE_W-1:0]       spare;
        logic [UGC_FRAME_W-1:0]       frame;
        logic [UGC_EP_NUM-1:0][7:0]   res;
        logic [UGC_EP_NUM-1:0]        pend;
        logic [15:0]                  dout;
        logic                         doe;
    } ugc_state_t;

    // Reset state; pin synchronisers start at the idle level of the strobes.
    localparam logic [3:0] UGC_PIN_IDLE = 4'h7;
    localparam ugc_state_t UGC_STATE_RST = '{pin_s1: UGC_PIN_IDLE, pin_s2: UGC_PIN_IDLE,
                                             default: '0};

endpackage

// ===== verif/ugc_cpu_model.sv
// Purpose: Processor model on the command/data pins.
// Assumes: Pins move 1 ns after a rising edge of mclk.
// Notes:   Released data lines carry the inverse of the last value.
`timescale 1ns/10ps
module ugc_cpu_model (
    // Clock and answer.
    input  wire logic        mclk,
    input  wire logic        cpu_doe,
    // Pins towards the device.
    output logic             cpu_cs_n,
    output logic             cpu_rd_n,
    output logic             cpu_wr_n,
    output logic             phase_select_line,
    output logic [15:0]      cpu_din
);
    // Idle pins at time zero.
    initial begin
        cpu_cs_n = 1'b1;
        cpu_rd_n = 1'b1;
        cpu_wr_n = 1'b1;
        phase_select_line = 1'b1;
        cpu_din = 16'h5a5a;
    end

    // Step n edges, then move off the edge.
    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask

    // One write; data held long enough for the synchronisers.
    task automatic wr(input logic ph, input logic [15:0] d);
        tick(1);
        cpu_cs_n = 1'b0;
        phase_select_line = ph;
        cpu_din = d;
        cpu_wr_n = 1'b0;
        tick(4);
        cpu_wr_n = 1'b1;
        cpu_cs_n = 1'b1;
        tick(5);
        cpu_din = ~d;
    endtask

    // One data read, held until the enable is seen high at an edge.
    task automatic rd();
        tick(1);
        cpu_cs_n = 1'b0;
        phase_select_line = 1'b0;
        cpu_rd_n = 1'b0;
        for (int i = 0; i < 12 && cpu_doe !== 1'b1; i++) @(posedge mclk);
        #1;
        cpu_rd_n = 1'b1;
        cpu_cs_n = 1'b1;
        tick(5);
    endtask
endmodule

// ===== verif/usb_device_general_commands_test.sv
// Purpose: Self-checking bench of the general command interpreter.
// Assumes: 16-bit bus plus a byte-wide copy on the same pins; engine events driven on mclk.
// Notes:   Reads are noted in a queue and judged by a monitor.
`timescale 1ns/10ps
module usb_device_general_commands_test;
    import ugc_pkg::*;
    localparam logic [7:0] PCODE = 8'h4c; // Arbitrary value.
    localparam logic [7:0] PREV  = 8'h21; // Arbitrary value.
    logic        mclk = 1'b0;
    logic        rst;
    logic        cs_n, rd_n, wr_n, ph, doe, doe_d = 1'b0;
    logic [15:0] din, dout, v;
    logic [10:0] f;
    logic        tg, usb_suspend, write_protect;
    logic        bdoe, bwp, bdoe_d = 1'b0;
    logic [15:0] bdout;
    ugc_txn_t    txn;
    ugc_sof_t    sof;
    logic [15:0] exp_q[$];
    logic [15:0] bexp_q[$];
    int          miscompares = 0;
    int          check_count = 0;
    int          cycles = 0;
    int          seed;

    always #50 mclk = ~mclk;

    ugc_general_cmd #(.PART_CODE(PCODE), .SILICON_REV(PREV)) dut (
        .mclk(mclk), .rst(rst), .cpu_cs_n(cs_n), .cpu_rd_n(rd_n), .cpu_wr_n(wr_n),
        .phase_select_line(ph), .cpu_din(din), .cpu_dout(dout), .cpu_doe(doe),
        .txn(txn), .sof(sof), .usb_suspend(usb_suspend), .write_protect(write_protect));
    ugc_cpu_model cpu (.mclk(mclk), .cpu_doe(doe), .cpu_cs_n(cs_n), .cpu_rd_n(rd_n),
        .cpu_wr_n(wr_n), .phase_select_line(ph), .cpu_din(din));
    // Byte-wide copy on the same pins, so low-byte-first pairing is exercised.
    ugc_general_cmd #(.BYTE_BUS(1'b1), .PART_CODE(PCODE), .SILICON_REV(PREV)) dut_b (
        .mclk(mclk), .rst(rst), .cpu_cs_n(cs_n), .cpu_rd_n(rd_n), .cpu_wr_n(wr_n),
        .phase_select_line(ph), .cpu_din(din), .cpu_dout(bdout), .cpu_doe(bdoe),
        .txn(txn), .sof(sof), .usb_suspend(usb_suspend), .write_protect(bwp));

    // One comparison, counted.
    task automatic check(input logic [15:0] e, input logic [15:0] a);
        check_count++;
        if (a !== e) begin
            miscompares++;
            $display("BAD t=%0t got %h expected %h", $time, a, e);
        end
    endtask

    // Verdict; a leftover note means a read never answered.
    task automatic summarize();
        if (exp_q.size() != 0 || bexp_q.size() != 0) begin
            $display("BAD t=%0t unanswered reads", $time);
            miscompares++;
        end
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // Monitor: the first cycle of each read answer takes the oldest note.
    always @(posedge mclk) begin
        doe_d <= doe;
        bdoe_d <= bdoe;
        cycles <= cycles + 1;
        if (doe === 1'b1 && doe_d === 1'b0) begin
            check(exp_q.size() > 0 ? exp_q.pop_front() : 16'hxxxx, dout);
        end
        // The byte-wide copy answers every read; only noted ones are judged.
        if (bdoe === 1'b1 && bdoe_d === 1'b0 && bexp_q.size() > 0) begin
            check(bexp_q.pop_front(), bdout);
        end
        if (cycles == 20000) begin
            $display("BAD t=%0t timeout", $time);
            miscompares++;
            summarize();
        end
    end

    // Command write; the ignored high byte gets noise.
    task automatic cmd(input logic [7:0] c);
        cpu.wr(1'b1, {8'($random(seed)), c});
    endtask

    task automatic rd_exp(input logic [7:0] c, input logic [15:0] e);
        cmd(c);
        exp_q.push_back(e);
        cpu.rd();
    endtask

    task automatic wr_cmd(input logic [7:0] c, input logic [15:0] d);
        cmd(c);
        cpu.wr(1'b0, d);
    endtask

    // One-cycle transaction report from the engine.
    task automatic ev(input logic [3:0] ep, input logic ok, input logic t, input ugc_err_t er);
        @(posedge mclk);
        #1;
        txn = '{1'b1, ep, ok, t, er};
        @(posedge mclk);
        #1;
        txn = '0;
    endtask

    initial begin
        seed = 19106;
        rst = 1'b1;
        txn = '0;
        sof = '0;
        usb_suspend = 1'b0;
        repeat (16) @(posedge mclk);
        #1;
        rst = 1'b0;
        rd_exp(UGC_CMD_ID_RD, {PCODE, PREV});
        rd_exp(UGC_CMD_SPARE_RD, 16'h0000);
        // Spare word round trips; top bits kept zero by the writer.
        for (int i = 0; i < 4; i++) begin
            v = 16'($random(seed)) & 16'h1fff;
            wr_cmd(UGC_CMD_SPARE_WR, v);
            rd_exp(UGC_CMD_SPARE_RD, v);
        end
        // Every endpoint, every error code.
        for (int i = 0; i < 16; i++) begin
            tg = 1'($random(seed));
            ev(4'(i), 1'b1, tg, ugc_err_t'(i));
            rd_exp({UGC_CMD_RESULT_NIB, 4'(i)}, {9'h000, tg, 1'b0, 4'(i), 1'b1});
        end
        // Status_overrun_flag overwrite; a failed packet leaves the toggle.
        ev(4'h2, 1'b1, 1'b1, UGC_ERR_NONE);
        ev(4'h2, 1'b0, 1'b0, UGC_ERR_NAK);
        rd_exp({UGC_CMD_RESULT_NIB, 4'h2}, 16'h00d2);
        ev(4'h2, 1'b1, 1'b0, UGC_ERR_NONE);
        rd_exp({UGC_CMD_RESULT_NIB, 4'h2}, 16'h0001);
        // Frame number of the last good start of frame.
        f = 11'($random(seed));
        @(posedge mclk);
        #1;
        sof = '{1'b1, f};
        @(posedge mclk);
        #1;
        sof = '0;
        rd_exp(UGC_CMD_FRAME_RD, {5'h00, f});
        // Suspend locks; wrong key refused; right key unlocks.
        usb_suspend = 1'b1;
        @(posedge mclk);
        #1;
        usb_suspend = 1'b0;
        check(16'h0001, {15'h0, write_protect});
        wr_cmd(UGC_CMD_SPARE_WR, 16'h0abc);
        rd_exp(UGC_CMD_SPARE_RD, 16'h0000);
        wr_cmd(UGC_CMD_UNLOCK, 16'h37aa);
        check(16'h0001, {15'h0, write_protect});
        wr_cmd(UGC_CMD_UNLOCK, UGC_UNLOCK_KEY);
        check(16'h0000, {15'h0, write_protect});
        rd_exp(UGC_CMD_SPARE_RD, v);
        // Byte-wide copy is still locked; its key goes low byte first.
        check(16'h0001, {15'h0, bwp});
        cmd(UGC_CMD_UNLOCK);
        cpu.wr(1'b0, {8'h00, UGC_UNLOCK_KEY[7:0]});
        cpu.wr(1'b0, {8'h00, UGC_UNLOCK_KEY[15:8]});
        check(16'h0000, {15'h0, bwp});
        check(16'h0000, {15'h0, write_protect});
        // Identity read twice: whole word here, low then high byte there.
        cmd(UGC_CMD_ID_RD);
        exp_q.push_back({PCODE, PREV});
        exp_q.push_back({PCODE, PREV});
        bexp_q.push_back({8'h00, PREV});
        bexp_q.push_back({8'h00, PCODE});
        cpu.rd();
        cpu.rd();
        repeat (4) @(posedge mclk);
        summarize();
    end
endmodule
